/* mgpc_top.sv */
// Purpose: Gain, second-path and phase-compensation control for metering
// Assumes: samp_stb pulses once per compensation sample, synchronous inputs
// Notes:   Bus answers on the second cycle of a request
//
// Chosen here: the Avalon-MM register port.

`timescale 1ns/1ns

// What this block does
// - Zero-cross interrupt forwarded only when enabled
// - Band-pass filter in RMS path when enabled
// - Quarter bit divides voltage gain by four
// - Path two reactive from I1, sign inverted
// - I2 sign bit selects positive or negative
// - I2 scaled by two to exponent field
// - Delay target bit picks voltage or I1
// - Delay value is upper six, lower two
// - One delay step is 0.0055 degree
// - Voltage scaled by two to its exponent
module mgpc_top
	import mgpc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic [15:0]      avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             samp_stb,
	input  wire mgpc_samples_type samp_in,
	input  wire logic             zc_event,
	output mgpc_result_type       res_out,
	output logic                  res_valid,
	output logic                  path2_active,
	output logic                  zc_irq
);

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic mgpc_hit(input logic [15:0] a,
		input logic [13:0] idx);
		return a == {idx, 2'b00};
	endfunction

	// Exponent saturates at five so an illegal field cannot overshift
	function automatic logic signed [MGPC_W-1:0] mgpc_pow2(
		input logic signed [MGPC_W-1:0] x, input logic [2:0] e);
		logic [2:0] s;
		s = (e > MGPC_EXP_MAX) ? MGPC_EXP_MAX : e;
		return x <<< s;
	endfunction

	// ****************************************
	// Register bus
	// ****************************************
	mgpc_bus_type bus_reg;
	mgpc_bus_type bus_next;
	logic [7:0]   gain2_reg;
	logic [7:0]   ctrl3_reg;
	logic [7:0]   phc1_reg;
	logic [7:0]   noload_reg;
	logic [31:0]  rdata_reg;
	logic [31:0]  rdata_next;
	logic [7:0]   rd_byte;

	wire acc    = avs_read | avs_write;
	wire wr_go  = (bus_reg == MGPC_ACK) && avs_write && avs_byteenable[0];
	wire hit_g2 = mgpc_hit(avs_address, MGPC_IDX_GAIN2);
	wire hit_c3 = mgpc_hit(avs_address, MGPC_IDX_CTRL3);
	wire hit_p1 = mgpc_hit(avs_address, MGPC_IDX_PHC1);
	wire hit_nl = mgpc_hit(avs_address, MGPC_IDX_NOLOAD);

	// Unmapped addresses read zero and swallow writes
	assign rd_byte = hit_g2 ? gain2_reg :
		hit_c3 ? ctrl3_reg :
		hit_p1 ? phc1_reg :
		hit_nl ? noload_reg : 8'h00;
	assign rdata_next = {24'h000000, rd_byte};
	assign bus_next = (bus_reg == MGPC_ACK) ? MGPC_WAIT :
		(acc ? MGPC_ACK : MGPC_WAIT);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_reg   <= MGPC_WAIT;
			rdata_reg <= 32'h00000000;
		end else if (ce) begin
			bus_reg <= bus_next;
			if (bus_reg == MGPC_WAIT && acc) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gain2_reg  <= MGPC_GAIN2_RST;
			ctrl3_reg  <= MGPC_CTRL3_RST;
			phc1_reg   <= MGPC_PHC1_RST;
			noload_reg <= MGPC_NOLOAD_RST;
		end else if (ce && wr_go) begin
			if (hit_g2) begin
				gain2_reg <= avs_writedata[7:0];
			end
			if (hit_c3) begin
				ctrl3_reg <= avs_writedata[7:0];
			end
			if (hit_p1) begin
				phc1_reg <= avs_writedata[7:0];
			end
			if (hit_nl) begin
				noload_reg <= avs_writedata[7:0] & MGPC_NOLOAD_MSK;
			end
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = bus_reg[0];

	// ****************************************
	// Field decode
	// ****************************************
	wire       zc_en   = ctrl3_reg[MGPC_ZC_BIT];
	wire       bpf_en  = ctrl3_reg[MGPC_BPF_BIT];
	wire       qtr     = ctrl3_reg[MGPC_QTR_BIT];
	wire       func    = ctrl3_reg[MGPC_FUNC_BIT];
	wire       i2_neg  = ctrl3_reg[MGPC_SIGN_BIT];
	wire [2:0] i2_exp  = ctrl3_reg[MGPC_EXP_MSB:MGPC_EXP_LSB];
	wire [2:0] v_exp   = gain2_reg[MGPC_EXP_MSB:MGPC_EXP_LSB];
	wire       tgt_v   = phc1_reg[MGPC_TGT_BIT];
	wire [MGPC_DLY_W-1:0] dly_val = {phc1_reg[MGPC_UPPER_MSB:0],
		noload_reg[MGPC_LOWER_MSB:0]};
	wire stb_go = ce && samp_stb;

	// ****************************************
	// Gain and second path
	// ****************************************
	logic signed [MGPC_W-1:0] v_gain;
	logic signed [MGPC_W-1:0] v_scaled;
	logic signed [MGPC_W-1:0] i2_gain;
	logic signed [MGPC_W-1:0] i2_signed;
	logic signed [MGPC_W-1:0] path2_next;

	assign v_gain     = mgpc_pow2(samp_in.v, v_exp);
	assign v_scaled   = qtr ? (v_gain >>> 2) : v_gain;
	assign i2_gain    = mgpc_pow2(samp_in.i2, i2_exp);
	assign i2_signed  = i2_neg ? -i2_gain : i2_gain;
	// Reactive sense is inverted so positive I1 lands in the negative sums
	assign path2_next = func ? i2_signed : -samp_in.i1;

	// ****************************************
	// Band-pass for the RMS path
	// ****************************************
	// (x[n]-x[n-2])/2 removes DC and Nyquist at the cost of harmonic loss
	logic signed [MGPC_W-1:0] rms_in  [2];
	logic signed [MGPC_W-1:0] rms_sel [2];
	assign rms_in[0] = samp_in.v;
	assign rms_in[1] = samp_in.i1;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_bpf
			logic signed [MGPC_W-1:0] h1_reg;
			logic signed [MGPC_W-1:0] h2_reg;
			logic signed [MGPC_W:0]   diff;
			assign diff = {rms_in[g][MGPC_W-1], rms_in[g]} -
				{h2_reg[MGPC_W-1], h2_reg};
			assign rms_sel[g] = bpf_en ? diff[MGPC_W:1] : rms_in[g];
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					h1_reg <= '0;
					h2_reg <= '0;
				end else if (stb_go) begin
					h1_reg <= rms_in[g];
					h2_reg <= h1_reg;
				end
			end
		end
	endgenerate

	// ****************************************
	// Phase compensation delay line
	// ****************************************
	logic signed [MGPC_W-1:0] dly_mem [MGPC_DLY_N];
	logic [MGPC_DLY_W-1:0]    wr_ptr_reg;
	logic signed [MGPC_W-1:0] dly_src;
	logic signed [MGPC_W-1:0] dly_out;
	logic signed [MGPC_W-1:0] v_next;
	logic signed [MGPC_W-1:0] i1_next;
	logic [MGPC_DLY_W-1:0]    rd_ptr;

	// Only the selected signal passes through the memory
	assign dly_src = tgt_v ? v_scaled : samp_in.i1;
	assign rd_ptr  = wr_ptr_reg - dly_val;
	assign dly_out = (dly_val == 8'h00) ? dly_src : dly_mem[rd_ptr];
	assign v_next  = tgt_v ? dly_out : v_scaled;
	assign i1_next = tgt_v ? samp_in.i1 : dly_out;

	// Memory has no reset; stale words show only for dly_val strobes
	always_ff @(posedge clk) begin
		if (stb_go) begin
			dly_mem[wr_ptr_reg] <= dly_src;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= 8'h00;
		end else if (stb_go) begin
			wr_ptr_reg <= wr_ptr_reg + 8'h01;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	mgpc_result_type res_reg;
	logic            valid_reg;
	logic            irq_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			res_reg   <= '0;
			valid_reg <= 1'b0;
			irq_reg   <= 1'b0;
		end else if (ce) begin
			valid_reg <= samp_stb;
			irq_reg   <= zc_event && zc_en;
			if (samp_stb) begin
				res_reg.v      <= v_next;
				res_reg.i1     <= i1_next;
				res_reg.path2  <= path2_next;
				res_reg.rms_v  <= rms_sel[0];
				res_reg.rms_i1 <= rms_sel[1];
			end
		end
	end

	assign res_out      = res_reg;
	assign res_valid    = valid_reg;
	assign zc_irq       = irq_reg;
	assign path2_active = ctrl3_reg[MGPC_FUNC_BIT];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_irq_gate;
		ce |=> zc_irq == $past(zc_event && zc_en);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("zero-cross irq not gated by enable");

	property p_bpf_off;
		stb_go && !bpf_en |=> res_out.rms_v == $past(samp_in.v);
	endproperty
	a_bpf_off: assert property (p_bpf_off)
		else $error("rms path altered with filter off");

	// Gain of four quartered keeps the low bits and wraps the top two
	property p_quarter;
		stb_go && qtr && v_exp == 3'h2 && !tgt_v
		|=> res_out.v == {{2{$past(samp_in.v[MGPC_W-3])}},
			$past(samp_in.v[MGPC_W-3:0])};
	endproperty
	a_quarter: assert property (p_quarter)
		else $error("gain of four quartered is not unity");

	property p_react;
		stb_go && !func |=> res_out.path2 == -$past(samp_in.i1);
	endproperty
	a_react: assert property (p_react)
		else $error("reactive path not inverted I1");

	property p_active;
		stb_go && func && !i2_neg && i2_exp == 3'h0
		|=> res_out.path2 == $past(samp_in.i2);
	endproperty
	a_active: assert property (p_active)
		else $error("active path not unity I2");

	property p_i2_neg;
		stb_go && func && i2_neg && i2_exp == 3'h0
		|=> res_out.path2 == -$past(samp_in.i2);
	endproperty
	a_i2_neg: assert property (p_i2_neg)
		else $error("negative I2 gain not applied");

	property p_i2_exp;
		stb_go && func && !i2_neg && i2_exp == 3'h1
		|=> res_out.path2 == {$past(samp_in.i2[MGPC_W-2:0]), 1'b0};
	endproperty
	a_i2_exp: assert property (p_i2_exp)
		else $error("I2 gain of two not applied");

	property p_tgt_v;
		stb_go && tgt_v |=> res_out.i1 == $past(samp_in.i1);
	endproperty
	a_tgt_v: assert property (p_tgt_v)
		else $error("I1 delayed while voltage selected");

	property p_v_exp;
		stb_go && !qtr && v_exp == 3'h0 && !tgt_v
		|=> res_out.v == $past(samp_in.v);
	endproperty
	a_v_exp: assert property (p_v_exp)
		else $error("voltage gain of one not unity");

	property p_dly_zero;
		stb_go && !tgt_v && dly_val == 8'h00
		|=> res_out.i1 == $past(samp_in.i1);
	endproperty
	a_dly_zero: assert property (p_dly_zero)
		else $error("zero delay not transparent");

	property p_bus_ack;
		acc && avs_waitrequest && ce |=> !avs_waitrequest;
	endproperty
	a_bus_ack: assert property (p_bus_ack)
		else $error("bus request not answered next cycle");

	c_active: cover property (stb_go && func && i2_neg);
	c_delay:  cover property (stb_go && dly_val != 8'h00);
	c_irq:    cover property (zc_irq);
	c_write:  cover property (wr_go && hit_p1);

endmodule

/* mgpc_pkg.sv */
// Purpose: Shared constants and types of the metering gain/phase block
// Assumes: 32-bit Avalon-MM, register index times four is the byte address
// Notes:   Sample words are signed two's complement

package mgpc_pkg;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [13:0] MGPC_IDX_GAIN2  = 14'h2879;
	localparam logic [13:0] MGPC_IDX_CTRL3  = 14'h287A;
	localparam logic [13:0] MGPC_IDX_PHC1   = 14'h287B;
	localparam logic [13:0] MGPC_IDX_NOLOAD = 14'h287F;

	localparam logic [7:0] MGPC_GAIN2_RST  = 8'h00;
	localparam logic [7:0] MGPC_CTRL3_RST  = 8'h00;
	localparam logic [7:0] MGPC_PHC1_RST   = 8'h00;
	localparam logic [7:0] MGPC_NOLOAD_RST = 8'h00;
	localparam logic [7:0] MGPC_NOLOAD_MSK = 8'h03;

	localparam int MGPC_ZC_BIT    = 7;
	localparam int MGPC_BPF_BIT   = 6;
	localparam int MGPC_QTR_BIT   = 5;
	localparam int MGPC_FUNC_BIT  = 4;
	localparam int MGPC_SIGN_BIT  = 3;
	localparam int MGPC_EXP_MSB   = 2;
	localparam int MGPC_EXP_LSB   = 0;
	localparam int MGPC_TGT_BIT   = 7;
	localparam int MGPC_UPPER_MSB = 5;
	localparam int MGPC_LOWER_MSB = 1;
	localparam logic [2:0] MGPC_EXP_MAX = 3'h5;

	// ****************************************
	// Sample path and timing
	// ****************************************
	localparam int MGPC_W       = 24;
	localparam int MGPC_DLY_W   = 8;
	localparam int MGPC_DLY_N   = 256;
	localparam int MGPC_CLK_HZ  = 100000000;
	localparam int MGPC_SMPL_HZ = 3276800;
	// Phase step per delay lsb in 1e-4 degree, full range in 1e-1 degree
	localparam int MGPC_STEP_E4 = 55;
	localparam int MGPC_RANGE_E1 = 14;
	localparam int MGPC_CLK_PER_SMPL = MGPC_CLK_HZ / MGPC_SMPL_HZ;

	typedef struct packed {
		logic signed [MGPC_W-1:0] v;
		logic signed [MGPC_W-1:0] i1;
		logic signed [MGPC_W-1:0] i2;
	} mgpc_samples_type;

	typedef struct packed {
		logic signed [MGPC_W-1:0] v;
		logic signed [MGPC_W-1:0] i1;
		logic signed [MGPC_W-1:0] path2;
		logic signed [MGPC_W-1:0] rms_v;
		logic signed [MGPC_W-1:0] rms_i1;
	} mgpc_result_type;

	typedef enum logic [1:0] {
		MGPC_WAIT = 2'b01,
		MGPC_ACK  = 2'b10
	} mgpc_bus_type;

endpackage

/* tb_mgpc_top.sv */
// Purpose: Self-checking bench for the metering gain/phase block
// Assumes: Bus acks on the second cycle, results one cycle after a strobe
// Notes:   Delay memory is unreset, so warm-up outputs are masked out

`timescale 1ns/1ns

module tb_mgpc_top
	import mgpc_pkg::*;
;
	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	logic             ce = 1'b1;
	logic [15:0]      avs_address = 16'h0000;
	logic             avs_read = 1'b0;
	logic             avs_write = 1'b0;
	logic [31:0]      avs_writedata = 32'h0;
	logic [3:0]       avs_byteenable = 4'h0;
	logic [31:0]      avs_readdata;
	logic             avs_waitrequest;
	logic             samp_stb = 1'b0;
	mgpc_samples_type samp_in = '0;
	logic             zc_event = 1'b0;
	mgpc_result_type  res_out;
	logic             res_valid;
	logic             path2_active;
	logic             zc_irq;
	int               n_errors = 0;
	int               tests_run = 0;
	int               cyc = 0;
	logic [31:0]      dq[$];
	mgpc_result_type  rq[$];
	logic [4:0]       mq[$];
	logic             zval = 1'b0;
	logic             zpend = 1'b0;

	mgpc_top u_mgpc_top (.clk(clk), .rstn(rstn), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .samp_stb(samp_stb),
		.samp_in(samp_in), .zc_event(zc_event), .res_out(res_out),
		.res_valid(res_valid), .path2_active(path2_active),
		.zc_irq(zc_irq));

	always #5 clk = ~clk;

	// ****************************************
	// Compare and report
	// ****************************************
	task automatic cmp(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmp_res(input mgpc_result_type e, g, input logic [4:0] m);
		if (m[4]) cmp("v", e.v, g.v);
		if (m[3]) cmp("i1", e.i1, g.i1);
		if (m[2]) cmp("path2", e.path2, g.path2);
		if (m[1]) cmp("rms_v", e.rms_v, g.rms_v);
		if (m[0]) cmp("rms_i1", e.rms_i1, g.rms_i1);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ****************************************
	// Drivers
	// ****************************************
	// Each task lets one more edge pass, zc two, so no strobe is set twice at once
	task automatic acc(input logic [13:0] idx, input logic w,
		input logic [7:0] d, input logic be);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_byteenable <= {3'h0, be};
		if (w) avs_write <= 1'b1;
		else avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		acc(idx, 1'b1, d, 1'b1);
	endtask

	task automatic rd(input logic [13:0] idx, input logic [7:0] e);
		dq.push_back({24'h0, e});
		acc(idx, 1'b0, 8'h00, 1'b0);
	endtask

	task automatic smp(input mgpc_samples_type s, input mgpc_result_type x,
		input logic [4:0] m);
		rq.push_back(x);
		mq.push_back(m);
		samp_stb <= 1'b1;
		samp_in <= s;
		@(posedge clk);
		samp_stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic zc(input logic en);
		zval = en;
		zc_event <= 1'b1;
		@(posedge clk);
		zc_event <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// ****************************************
	// Monitor
	// ****************************************
	always @(posedge clk) begin
		cyc++;
		if (avs_read && avs_waitrequest === 1'b0)
			cmp("readdata", dq.pop_front(), avs_readdata);
		// A result with nothing noted is an error, not a silent skip
		if (res_valid === 1'b1) begin
			if (rq.size() == 0) begin
				n_errors++;
				$display("MISMATCH res_valid expected 0 seen 1");
			end else
				cmp_res(rq.pop_front(), res_out, mq.pop_front());
		end
		cmp("zc_irq", {31'h0, zpend & zval}, {31'h0, zc_irq});
		zpend <= zc_event;
		if (cyc == 20000) begin
			n_errors++;
			$display("MISMATCH timeout expected 0 seen 1");
			end_of_test();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		mgpc_samples_type s;
		mgpc_samples_type h[14];
		mgpc_result_type  x;
		logic [7:0]       d;
		logic [2:0]       e;
		logic             fn;
		logic             q;
		logic signed [MGPC_W-1:0] t;
		void'($urandom(80));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(MGPC_IDX_CTRL3, MGPC_CTRL3_RST);
		rd(MGPC_IDX_PHC1, MGPC_PHC1_RST);
		rd(MGPC_IDX_GAIN2, MGPC_GAIN2_RST);
		rd(MGPC_IDX_NOLOAD, MGPC_NOLOAD_RST);
		d = 8'($urandom);
		wr(MGPC_IDX_CTRL3, d);
		rd(MGPC_IDX_CTRL3, d);
		acc(MGPC_IDX_CTRL3, 1'b1, ~d, 1'b0);
		rd(MGPC_IDX_CTRL3, d);
		rd(14'h0100, 8'h00);
		wr(MGPC_IDX_PHC1, ~d);
		rd(MGPC_IDX_PHC1, ~d);
		for (int i = 0; i < 2; i++) begin
			wr(MGPC_IDX_CTRL3, {i[0], 7'h00});
			zc(i[0]);
		end
		// Only the two low bits of the no-load register hold a value
		wr(MGPC_IDX_NOLOAD, 8'hFF);
		rd(MGPC_IDX_NOLOAD, MGPC_NOLOAD_MSK);
		wr(MGPC_IDX_GAIN2, 8'h05);
		rd(MGPC_IDX_GAIN2, 8'h05);
		wr(MGPC_IDX_PHC1, 8'h00);
		wr(MGPC_IDX_NOLOAD, 8'h00);
		// Gain, sign and path-two function over every legal exponent
		for (int k = 0; k < 24; k++) begin
			e = 3'(k / 4);
			fn = k[1];
			q = k[0];
			wr(MGPC_IDX_CTRL3, {2'b00, q, fn, k[0], e});
			wr(MGPC_IDX_GAIN2, {5'h00, e});
			cmp("path2_active", {31'h0, fn}, {31'h0, path2_active});
			s = {24'($urandom), 24'($urandom), 24'($urandom)};
			t = s.v <<< e;
			x.v = q ? t >>> 2 : t;
			x.i1 = s.i1;
			t = s.i2 <<< e;
			x.path2 = fn ? (k[0] ? -t : t) : -s.i1;
			x.rms_v = '0;
			x.rms_i1 = '0;
			smp(s, x, 5'h1C);
		end
		// Constant input settles to zero through the band-pass
		wr(MGPC_IDX_GAIN2, 8'h00);
		wr(MGPC_IDX_CTRL3, 8'h40);
		s = {24'($urandom), 24'($urandom), 24'($urandom)};
		x = '0;
		for (int n = 0; n < 4; n++)
			smp(s, x, (n < 2) ? 5'h00 : 5'h03);
		wr(MGPC_IDX_CTRL3, 8'h00);
		x.rms_v = s.v;
		x.rms_i1 = s.i1;
		smp(s, x, 5'h03);
		// Delay of six samples: upper field one, lower field two
		for (int tg = 0; tg < 2; tg++) begin
			wr(MGPC_IDX_PHC1, {tg[0], 7'h01});
			wr(MGPC_IDX_NOLOAD, 8'h02);
			for (int n = 0; n < 14; n++) begin
				s = {24'($urandom), 24'($urandom), 24'($urandom)};
				h[n] = s;
				x.v = (tg && n >= 6) ? h[n-6].v : s.v;
				x.i1 = (!tg && n >= 6) ? h[n-6].i1 : s.i1;
				x.path2 = -s.i1;
				smp(s, x, (n >= 6) ? 5'h1C : (tg ? 5'h0C : 5'h14));
			end
		end
		// Clock enable low must swallow a strobe without any result
		ce <= 1'b0;
		samp_stb <= 1'b1;
		@(posedge clk);
		samp_stb <= 1'b0;
		ce <= 1'b1;
		repeat (5) @(posedge clk);
		cmp("queues", 32'h0, 32'(rq.size() + dq.size()));
		end_of_test();
	end

endmodule
